// ===== design/mmpc_pkg.sv
package mmpc_pkg;

	// ==========================================
	// Register offsets
	localparam logic [7:0] MMPC_CMD_OFS = 8'h14;
	localparam logic [7:0] MMPC_DATA_OFS = 8'h18;
	localparam logic [7:0] MMPC_FCR_OFS = 8'h1C;

	// ==========================================
	// Field positions
	localparam int MMPC_PHY_LSB = 11;
	localparam int MMPC_REG_LSB = 6;
	localparam int MMPC_WNR_BIT = 1;
	localparam int MMPC_BUSY_BIT = 0;
	localparam int MMPC_PT_LSB = 16;
	localparam int MMPC_HON_BIT = 1;
	localparam int MMPC_SEND_BIT = 0;

	// ==========================================
	// Reset values
	localparam logic [4:0] MMPC_PHY_RST = 5'h0B;
	localparam logic [4:0] MMPC_REG_RST = 5'h0B;
	localparam logic MMPC_WNR_RST = 1'b0;
	localparam logic [15:0] MMPC_DATA_RST = 16'h0000;
	localparam logic [15:0] MMPC_PT_RST = 16'h0050;
	localparam logic MMPC_HON_RST = 1'b1;
	localparam logic MMPC_SEND_RST = 1'b0;

	// ==========================================
	// Timing
	localparam int MMPC_CLK_NS = 8;
	localparam int MMPC_MDC_HALF_NS = 200;
	localparam int MMPC_MDC_HALF_CYC =
		(MMPC_MDC_HALF_NS + MMPC_CLK_NS - 1) / MMPC_CLK_NS;
	localparam int MMPC_SLOT_BITS = 512;
	localparam int MMPC_NIB_BITS = 4;
	localparam int MMPC_SLOT_NIBBLES = MMPC_SLOT_BITS / MMPC_NIB_BITS;

	// ==========================================
	// Management frame
	localparam logic [31:0] MMPC_PREAMBLE = 32'hFFFFFFFF;
	localparam logic [1:0] MMPC_START = 2'h1;
	localparam logic [1:0] MMPC_OP_WR = 2'h1;
	localparam logic [1:0] MMPC_OP_RD = 2'h2;
	localparam logic [1:0] MMPC_TA_WR = 2'h2;
	localparam logic [5:0] MMPC_LAST_IDX = 6'h3F;
	localparam logic [5:0] MMPC_TA_IDX = 6'h2E;
	localparam logic [5:0] MMPC_DATA_IDX = 6'h30;

	typedef enum logic [2:0] {
		MD_IDLE = 3'h1,
		MD_LOW = 3'h2,
		MD_HIGH = 3'h4
	} mmpc_md_state_t;

endpackage

// ===== design/mmpc_sync.sv
`timescale 1ns/100ps
module mmpc_sync (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic pin_in,
	output logic level,
	output logic rise
);
	logic meta_q;
	logic s2_q;
	logic s3_q;
	logic stable_q;
	logic rise_q;

	// ==========================================
	// Three stages, change taken when two agree
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			meta_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			stable_q <= 1'b0;
			rise_q <= 1'b0;
		end else begin
			meta_q <= pin_in;
			s2_q <= meta_q;
			s3_q <= s2_q;
			if (s2_q == s3_q)
				stable_q <= s3_q;
			rise_q <= (s2_q == s3_q) && s3_q && !stable_q;
		end
	end

	assign level = stable_q;
	assign rise = rise_q;
endmodule // mmpc_sync

// ===== design/mmpc_div.sv
`timescale 1ns/100ps
module mmpc_div #(
	parameter int N = 25,
	parameter int W = $clog2(N + 1)
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clr,
	input wire logic en,
	output logic tick
);
	logic [W-1:0] cnt_q;
	logic tick_q;

	// ==========================================
	// One-cycle pulse every N enabled cycles
	always_ff @(posedge sys_clk) begin
		if (sys_rst || clr) begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= 1'b0;
			if (en) begin
				if (cnt_q == W'(N - 1)) begin
					cnt_q <= '0;
					tick_q <= 1'b1;
				end else begin
					cnt_q <= cnt_q + W'(1);
				end
			end
		end
	end

	assign tick = tick_q;
endmodule // mmpc_div

// ===== design/mmpc_top.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps

// What this block does
// - Five-bit PHY select chooses one of 32 PHY addresses per transaction.
// - Five-bit register select addresses the register inside that PHY.
// - Direction bit one performs a management write, zero a read.
// - Busy flag stays one through the transaction, zero once finished.
// - Sixteen-bit data field supplies write data and receives read data.
// - Programmed pause duration goes into every transmitted pause frame.
// - With honour enabled, received pause frames hold transmitter idle.
// - Writing one to the pause request bit starts a pause frame.
// - Pause request stays one while sending, cleared when frame is done.
module mmpc_top
	import mmpc_pkg::*;
#(
	parameter int MDC_HALF = MMPC_MDC_HALF_CYC,
	parameter int SLOT_NIBBLES = MMPC_SLOT_NIBBLES
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic mdc,
	output logic mdio_o,
	output logic mdio_oe,
	input wire logic mdio_i,
	input wire logic mii_tx_clk,
	output logic pause_tx_req,
	output logic [15:0] pause_tx_time,
	input wire logic pause_tx_done,
	input wire logic rx_pause_valid,
	input wire logic [15:0] rx_pause_time,
	output logic tx_hold
);

	// ==========================================
	// Registers and state
	logic [4:0] phy_sel_q;
	logic [4:0] reg_sel_q;
	logic wnr_q;
	logic busy_q;
	logic [15:0] data_q;
	logic [15:0] pause_dur_q;
	logic honour_q;
	logic send_q;
	logic [31:0] rdata_q;
	mmpc_md_state_t md_q;
	logic [63:0] sh_q;
	logic [5:0] bit_q;
	logic [15:0] rd_sh_q;
	logic mdc_q;
	logic mdio_o_q;
	logic mdio_oe_q;
	logic [15:0] quanta_q;
	logic hold_q;

	// ==========================================
	// Decoded strobes
	logic wr_cmd;
	logic wr_data;
	logic wr_fcr;
	logic start;
	logic md_tick;
	logic mdio_lvl;
	logic txclk_rise;
	logic slot_tick;
	logic pause_load;
	logic frame_end;

	assign wr_cmd = reg_wr && (reg_addr == MMPC_CMD_OFS);
	assign wr_data = reg_wr && (reg_addr == MMPC_DATA_OFS);
	assign wr_fcr = reg_wr && (reg_addr == MMPC_FCR_OFS);
	assign start = wr_cmd && !busy_q;
	assign pause_load = rx_pause_valid && honour_q;
	assign frame_end = (md_q == MD_HIGH) && md_tick &&
		(bit_q == MMPC_LAST_IDX);

	// ==========================================
	// Clock divider and pin synchronisers
	mmpc_div #(
		.N(MDC_HALF)
	) u_mdc_div (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clr(md_q == MD_IDLE),
		.en(1'b1),
		.tick(md_tick)
	);

	mmpc_sync u_mdio_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.pin_in(mdio_i),
		.level(mdio_lvl),
		.rise()
	);

	mmpc_sync u_txclk_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.pin_in(mii_tx_clk),
		.level(),
		.rise(txclk_rise)
	);

	// Counts transmit nibbles into slot times
	mmpc_div #(
		.N(SLOT_NIBBLES)
	) u_slot_div (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clr(pause_load || (quanta_q == 16'h0000)),
		.en(txclk_rise),
		.tick(slot_tick)
	);

	// ==========================================
	// Management command register
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			phy_sel_q <= MMPC_PHY_RST;
			reg_sel_q <= MMPC_REG_RST;
			wnr_q <= MMPC_WNR_RST;
		end else if (start) begin
			phy_sel_q <= reg_wdata[MMPC_PHY_LSB +: 5];
			reg_sel_q <= reg_wdata[MMPC_REG_LSB +: 5];
			wnr_q <= reg_wdata[MMPC_WNR_BIT];
		end
	end

	// ==========================================
	// Busy flag
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			busy_q <= 1'b0;
		end else if (start) begin
			busy_q <= 1'b1;
		end else if (frame_end) begin
			busy_q <= 1'b0;
		end
	end

	// ==========================================
	// Management data register
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			data_q <= MMPC_DATA_RST;
		end else if (frame_end && !wnr_q) begin
			data_q <= rd_sh_q;
		end else if (wr_data && !busy_q) begin
			data_q <= reg_wdata[15:0];
		end
	end

	// ==========================================
	// Flow control register
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pause_dur_q <= MMPC_PT_RST;
			honour_q <= MMPC_HON_RST;
		end else if (wr_fcr) begin
			pause_dur_q <= reg_wdata[MMPC_PT_LSB +: 16];
			honour_q <= reg_wdata[MMPC_HON_BIT];
		end
	end

	// ==========================================
	// Pause send request
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			send_q <= MMPC_SEND_RST;
		end else if (wr_fcr && reg_wdata[MMPC_SEND_BIT] && !send_q) begin
			send_q <= 1'b1;
		end else if (pause_tx_done) begin
			send_q <= 1'b0;
		end
	end

	// ==========================================
	// Register read port
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rdata_q <= 32'h00000000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				MMPC_CMD_OFS: rdata_q <= {16'h0000, phy_sel_q,
					reg_sel_q, 4'h0, wnr_q, busy_q};
				MMPC_DATA_OFS: rdata_q <= {16'h0000, data_q};
				MMPC_FCR_OFS: rdata_q <= {pause_dur_q, 14'h0000,
					honour_q, send_q};
				default: rdata_q <= 32'h00000000;
			endcase
		end else begin
			rdata_q <= 32'h00000000;
		end
	end

	// ==========================================
	// Management frame sequencer
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			md_q <= MD_IDLE;
		end else begin
			unique case (md_q)
				MD_IDLE: begin
					if (start)
						md_q <= MD_LOW;
				end
				MD_LOW: begin
					if (md_tick)
						md_q <= MD_HIGH;
				end
				MD_HIGH: begin
					if (frame_end)
						md_q <= MD_IDLE;
					else if (md_tick)
						md_q <= MD_LOW;
				end
				default: md_q <= MD_IDLE;
			endcase
		end
	end

	// ==========================================
	// Frame shift register
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sh_q <= 64'h0000000000000000;
		end else if (start) begin
			sh_q <= {MMPC_PREAMBLE, MMPC_START,
				reg_wdata[MMPC_WNR_BIT] ? MMPC_OP_WR : MMPC_OP_RD,
				reg_wdata[MMPC_PHY_LSB +: 5],
				reg_wdata[MMPC_REG_LSB +: 5],
				MMPC_TA_WR, data_q};
		end else if ((md_q == MD_HIGH) && md_tick && !frame_end) begin
			sh_q <= {sh_q[62:0], 1'b0};
		end
	end

	// ==========================================
	// Frame bit counter
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			bit_q <= 6'h00;
		end else if (start) begin
			bit_q <= 6'h00;
		end else if ((md_q == MD_HIGH) && md_tick && !frame_end) begin
			bit_q <= bit_q + 6'h01;
		end
	end

	// ==========================================
	// Management clock output
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			mdc_q <= 1'b0;
		end else if (md_tick && (md_q == MD_LOW)) begin
			mdc_q <= 1'b1;
		end else if (md_tick && (md_q == MD_HIGH)) begin
			mdc_q <= 1'b0;
		end
	end

	// ==========================================
	// Data pin drive, changes on falling MDC
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			mdio_o_q <= 1'b0;
		end else if (start) begin
			mdio_o_q <= 1'b1;
		end else if (frame_end) begin
			mdio_o_q <= 1'b0;
		end else if ((md_q == MD_HIGH) && md_tick) begin
			mdio_o_q <= sh_q[62];
		end
	end

	// ==========================================
	// Data pin enable, released for a read turnaround
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			mdio_oe_q <= 1'b0;
		end else if (start) begin
			mdio_oe_q <= 1'b1;
		end else if (frame_end) begin
			mdio_oe_q <= 1'b0;
		end else if ((md_q == MD_HIGH) && md_tick && !wnr_q &&
			(bit_q + 6'h01 == MMPC_TA_IDX)) begin
			mdio_oe_q <= 1'b0;
		end
	end

	// ==========================================
	// Read data capture on rising MDC
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rd_sh_q <= 16'h0000;
		end else if ((md_q == MD_LOW) && md_tick && !wnr_q &&
			(bit_q >= MMPC_DATA_IDX)) begin
			rd_sh_q <= {rd_sh_q[14:0], mdio_lvl};
		end
	end

	// ==========================================
	// Received pause timer in slot times
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			quanta_q <= 16'h0000;
		end else if (!honour_q) begin
			quanta_q <= 16'h0000;
		end else if (pause_load) begin
			quanta_q <= rx_pause_time;
		end else if (slot_tick && (quanta_q != 16'h0000)) begin
			quanta_q <= quanta_q - 16'h0001;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			hold_q <= 1'b0;
		else
			hold_q <= honour_q && (quanta_q != 16'h0000);
	end

	// ==========================================
	// Outputs
	assign reg_rdata = rdata_q;
	assign mdc = mdc_q;
	assign mdio_o = mdio_o_q;
	assign mdio_oe = mdio_oe_q;
	assign pause_tx_req = send_q;
	assign pause_tx_time = pause_dur_q;
	assign tx_hold = hold_q;

endmodule // mmpc_top

// ===== sim/mmpc_phy_model.sv
`timescale 1ns/100ps
// ==========================================
// PHY management port model
module mmpc_phy_model (
	input wire logic sys_rst,
	input wire logic mdc,
	input wire logic mdio_o,
	input wire logic mdio_oe,
	input wire logic [15:0] rd_data,
	output logic mdio_i,
	output logic [63:0] frame
);
	logic [62:0] sh = '0;
	logic drv = 1'b0;
	logic val = 1'b0;
	logic is_rd = 1'b0;
	int c = 0;
	// Released line floats high through the pull-up
	assign mdio_i = mdio_oe ? mdio_o : (drv ? val : 1'b1);
	initial frame = '0;
	always @(posedge mdc or posedge sys_rst) begin
		if (sys_rst) begin
			c <= 0;
			drv <= 1'b0;
		end else begin
			sh <= {sh[61:0], mdio_i};
			if (c == 35) is_rd <= {sh[0], mdio_i} == 2'b10;
			drv <= is_rd && c >= 46 && c <= 62;
			val <= (c == 46) ? 1'b0 : rd_data[4'(62 - c)];
			if (c == 63) frame <= {sh, mdio_i};
			c <= (c == 63) ? 0 : c + 1;
		end
	end
endmodule // mmpc_phy_model

// ===== sim/mmpc_checker_assertions.sv
`timescale 1ns/100ps
module mmpc_checker
	import mmpc_pkg::*;
#(
	parameter int MDC_HALF = MMPC_MDC_HALF_CYC
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic mdc,
	input wire logic mdio_o,
	input wire logic mdio_oe,
	input wire logic pause_tx_req,
	input wire logic [15:0] pause_tx_time,
	input wire logic pause_tx_done,
	input wire logic rx_pause_valid,
	input wire logic [15:0] rx_pause_time,
	input wire logic tx_hold
);
	logic hon_q;
	logic [15:0] pt_q;
	int hcnt_q;
	wire fcr_wr = reg_wr && reg_addr == MMPC_FCR_OFS;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// ==========================================
	// Shadow of flow control fields
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			hon_q <= MMPC_HON_RST;
			pt_q <= MMPC_PT_RST;
		end else if (fcr_wr) begin
			hon_q <= reg_wdata[MMPC_HON_BIT];
			pt_q <= reg_wdata[31:16];
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst || !mdc) hcnt_q <= 0;
		else hcnt_q <= hcnt_q + 1;
	end
	// ==========================================
	// Assertions
	a_rdata_one_cycle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data outside answer cycle");
	a_frame_start_idle: assert property (
		$rose(mdio_oe) |-> mdio_o && !mdc)
		else $error("frame does not open with one and mdc low");
	a_mdc_half_period: assert property (
		$fell(mdc) |-> hcnt_q == MDC_HALF)
		else $error("mdc high phase length wrong");
	a_mdio_on_fall: assert property (
		$changed(mdio_o) && mdio_oe |-> $fell(mdc) || $rose(mdio_oe))
		else $error("mdio changed away from mdc fall");
	a_pause_req_start: assert property (
		fcr_wr && reg_wdata[MMPC_SEND_BIT] && !pause_tx_req
		|=> pause_tx_req)
		else $error("pause request not raised");
	a_pause_req_hold: assert property (
		pause_tx_req && !pause_tx_done |=> pause_tx_req)
		else $error("pause request dropped early");
	a_pause_req_clear: assert property (
		pause_tx_req && pause_tx_done |=> !pause_tx_req)
		else $error("pause request not cleared");
	a_pause_time_field: assert property (
		pause_tx_req |-> pause_tx_time == pt_q)
		else $error("pause time differs from duration");
	a_hold_on_pause: assert property (
		rx_pause_valid && hon_q && rx_pause_time != 0 |-> ##2 tx_hold)
		else $error("hold not raised");
	a_hold_ignored: assert property (
		rx_pause_valid && !hon_q && !tx_hold |-> ##2 !tx_hold)
		else $error("hold raised while disabled");
	c_frame: cover property ($rose(mdio_oe));
	c_pause_sent: cover property ($fell(pause_tx_req));
	c_hold: cover property ($fell(tx_hold));
endmodule // mmpc_checker

bind mmpc_top mmpc_checker #(.MDC_HALF(MDC_HALF)) mmpc_checker_i (.*);

// ===== sim/mmpc_top_tb.sv
`timescale 1ns/100ps
module mmpc_top_tb
	import mmpc_pkg::*;
;
	localparam int HALF = 4;
	localparam int SLOTN = 4;
	logic sys_clk, sys_rst, reg_wr, reg_rd, mdio_i, mii_tx_clk, wnr;
	logic mdc, mdio_o, mdio_oe, pause_tx_req, pause_tx_done;
	logic rx_pause_valid, tx_hold;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, v;
	logic [15:0] pause_tx_time, rx_pause_time, rd_data, dat;
	logic [63:0] frame;
	logic [4:0] phy, rg;
	int failures, n_tests, txc, n0, k, t;
	integer seed = 32'h0735046A;
	mmpc_top #(.MDC_HALF(HALF), .SLOT_NIBBLES(SLOTN)) mmpc_top_i (.*);
	mmpc_phy_model mmpc_phy_model_i (.sys_rst(sys_rst), .mdc(mdc),
		.mdio_o(mdio_o), .mdio_oe(mdio_oe), .rd_data(rd_data),
		.mdio_i(mdio_i), .frame(frame));
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	initial begin
		mii_tx_clk = 1'b0;
		forever #62.5 mii_tx_clk = ~mii_tx_clk;
	end
	always @(posedge mii_tx_clk) txc++;
	// ==========================================
	// Tasks and expectations
	task automatic report_and_stop();
		if (failures == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [63:0] e,
		input logic [63:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic stop_if(input logic bad);
		if (bad) begin
			failures++;
			report_and_stop();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	function automatic logic [31:0] exp_cmd(logic [4:0] p, logic [4:0] r,
		logic w, logic b);
		return {16'h0000, p, r, 4'h0, w, b};
	endfunction
	function automatic logic [63:0] exp_frame(logic [4:0] p, logic [4:0] r,
		logic w, logic [15:0] d);
		return {MMPC_PREAMBLE, MMPC_START, w ? MMPC_OP_WR : MMPC_OP_RD, p, r,
			MMPC_TA_WR, d};
	endfunction
	// ==========================================
	// Main sequence
	initial begin
		sys_rst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h00000000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		pause_tx_done = 1'b0;
		rx_pause_valid = 1'b0;
		rx_pause_time = 16'h0000;
		rd_data = 16'h0000;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(MMPC_CMD_OFS, v);
		chk("cmd", exp_cmd(MMPC_PHY_RST, MMPC_REG_RST, 1'b0, 1'b0), v);
		rd(MMPC_DATA_OFS, v);
		chk("data", 64'h0, v);
		rd(MMPC_FCR_OFS, v);
		chk("fcr", {MMPC_PT_RST, 14'h0000, MMPC_HON_RST, 1'b0}, v);
		rd(8'h20, v);
		chk("unmapped", 64'h0, v);
		for (k = 0; k < 6; k++) begin
			phy = (k == 0) ? 5'h1F : 5'($random(seed));
			rg = (k == 1) ? 5'h1F : 5'($random(seed));
			wnr = (k < 2) ? !k[0] : 1'($random(seed));
			dat = 16'($random(seed));
			rd_data = 16'($random(seed));
			wr(MMPC_DATA_OFS, {16'h0000, dat});
			wr(MMPC_CMD_OFS, exp_cmd(phy, rg, wnr, 1'b0));
			rd(MMPC_CMD_OFS, v);
			chk("cmd", exp_cmd(phy, rg, wnr, 1'b1), v);
			wr(MMPC_DATA_OFS, {16'h0000, ~dat});
			wr(MMPC_CMD_OFS, exp_cmd(~phy, ~rg, wnr, 1'b0));
			t = 0;
			do begin
				rd(MMPC_CMD_OFS, v);
				t++;
			end while (v[MMPC_BUSY_BIT] !== 1'b0 && t < 400);
			stop_if(v[MMPC_BUSY_BIT] !== 1'b0);
			chk("cmd", exp_cmd(phy, rg, wnr, 1'b0), v);
			chk("frame", exp_frame(phy, rg, wnr, wnr ? dat : rd_data), frame);
			rd(MMPC_DATA_OFS, v);
			chk("data", {16'h0000, wnr ? dat : rd_data}, v);
		end
		rd(MMPC_FCR_OFS, v);
		chk("pause_idle", 64'h0, 64'(v[MMPC_SEND_BIT]));
		dat = 16'($random(seed));
		wr(MMPC_FCR_OFS, {dat, 16'h0003});
		#1 chk("pause_tx_req", 1'b1, pause_tx_req);
		chk("pause_tx_time", dat, pause_tx_time);
		wr(MMPC_FCR_OFS, {dat, 16'h0003});
		rd(MMPC_FCR_OFS, v);
		chk("fcr", {dat, 16'h0003}, v);
		@(posedge sys_clk);
		pause_tx_done <= 1'b1;
		@(posedge sys_clk);
		pause_tx_done <= 1'b0;
		rd(MMPC_FCR_OFS, v);
		chk("fcr", {dat, 16'h0002}, v);
		for (k = 0; k < 3; k++) begin
			t = (k == 2) ? 5 : k + 1;
			if (k == 2) wr(MMPC_FCR_OFS, {dat, 16'h0000});
			@(posedge mii_tx_clk);
			repeat (6) @(posedge sys_clk);
			rx_pause_time <= 16'(t);
			rx_pause_valid <= 1'b1;
			@(posedge sys_clk);
			rx_pause_valid <= 1'b0;
			n0 = txc;
			@(posedge sys_clk);
			#1 chk("tx_hold", k != 2, tx_hold);
			for (int i = 0; i < 3000 && tx_hold === 1'b1; i++) @(posedge sys_clk);
			stop_if(tx_hold !== 1'b0);
			if (k < 2) chk("hold_len", 64'(t * SLOTN), 64'(txc - n0));
		end
		report_and_stop();
	end
endmodule // mmpc_top_tb
